// ### rtl/host_port_pkg.sv
package host_port_pkg;

  // ------------------------------------------------------------
  // Widths of the host pins
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 10;
  localparam int ADDR_HI_W = ADDR_W - DATA_W;
  // Control pins, bit positions in the synchroniser bundle.
  localparam int CTL_W = 6;
  localparam int CTL_CS = 0;
  localparam int CTL_RD = 1;
  localparam int CTL_WR = 2;
  localparam int CTL_ALE = 3;
  localparam int CTL_STYLE = 4;
  localparam int CTL_MUX = 5;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  // Active-low select, strobes and interrupt rest high, the rest low.
  localparam logic [CTL_W-1:0] CTL_RST = 6'h07;
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic IRQ_N_RST = 1'b1;

  // ------------------------------------------------------------
  // Access sequencer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } access_state_t;

endpackage : host_port_pkg

// ### rtl/pin_sync.sv
module pin_sync
  import host_port_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  // ------------------------------------------------------------
  // Two flip-flop synchroniser, one chain per bit
  // ------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_ff;
    logic stable_ff;
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        meta_ff <= RST_VAL[i];
        stable_ff <= RST_VAL[i];
      end else begin
        meta_ff <= pin_in[i];
        stable_ff <= meta_ff;
      end
    end
    assign pin_sync_out[i] = stable_ff;
  end

endmodule : pin_sync

// ### rtl/host_control_port.sv
// Notes on behaviour
// - Style pin high selects single-strobe bus.
// - Strobe meaning follows selected style; select is the same in both.
// - Split read valid while read and select low.
// - Write valid while write and select low.
// - Reset held level sensitive, all logic reset.
// - Interrupt request output signals internal event.
// - Eight-bit data bus, device drives on reads.
// - Ten-bit address, multiplexed or separate bus.
// - Select, strobes and interrupt active low, reset active high.
module host_control_port
  import host_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic bus_style,
  input wire logic addr_mux,
  input wire logic ale,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [DATA_W-1:0] host_data_in,
  output logic [DATA_W-1:0] host_data_out,
  output logic host_data_oe,
  output logic irq_n,
  input wire logic event_req,
  output logic reg_rd_stb,
  output logic reg_wr_stb,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wr_data,
  input wire logic [DATA_W-1:0] reg_rd_data
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [CTL_W-1:0] ctl_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;

  pin_sync #(.WIDTH(CTL_W), .RST_VAL(CTL_RST)) u_ctl_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in({addr_mux, bus_style, ale, write_strobe_n, read_strobe_n, chip_select_n}),
    .pin_sync_out(ctl_s)
  );

  pin_sync #(.WIDTH(ADDR_W), .RST_VAL(ADDR_RST)) u_addr_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(host_addr),
    .pin_sync_out(addr_s)
  );

  pin_sync #(.WIDTH(DATA_W), .RST_VAL(DATA_RST)) u_data_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(host_data_in),
    .pin_sync_out(data_s)
  );

  // ------------------------------------------------------------
  // Strobe decode
  // ------------------------------------------------------------
  wire cs_s = ctl_s[CTL_CS];
  wire rd_s = ctl_s[CTL_RD];
  wire wr_s = ctl_s[CTL_WR];
  wire ale_s = ctl_s[CTL_ALE];
  wire style_s = ctl_s[CTL_STYLE];
  wire mux_s = ctl_s[CTL_MUX];
  // In single-strobe style the write pin is a read/write level and the read pin is ignored.
  wire single_rd = ~cs_s & wr_s;
  wire split_rd = ~cs_s & ~rd_s;
  wire rd_act = style_s ? single_rd : split_rd;
  wire wr_act = ~cs_s & ~wr_s;
  wire [ADDR_W-1:0] mux_addr = {addr_s[ADDR_W-1:DATA_W], data_s};

  // ------------------------------------------------------------
  // Address latch for multiplexed buses
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] ale_addr_ff;
  wire [ADDR_W-1:0] nxt_ale_addr = (ale_s & mux_s) ? mux_addr : ale_addr_ff;
  wire [ADDR_W-1:0] eff_addr = mux_s ? ale_addr_ff : addr_s;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ale_addr_ff <= ADDR_RST;
    end else begin
      ale_addr_ff <= nxt_ale_addr;
    end
  end

  // ------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------
  access_state_t state_ff;
  access_state_t nxt_state;
  logic rd_stb_ff;
  logic wr_stb_ff;
  logic oe_ff;
  logic irq_n_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] dout_ff;

  wire idle = (state_ff == ST_IDLE);
  wire start_rd = idle & rd_act;
  wire start_wr = idle & ~rd_act & wr_act;
  wire end_wr = (state_ff == ST_WRITE) & ~wr_act;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start_rd) begin
          nxt_state = ST_READ;
        end else if (start_wr) begin
          nxt_state = ST_WRITE;
        end
      end
      ST_READ: begin
        if (!rd_act) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (!wr_act) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // The bus is driven only while the read window is open.
  wire nxt_oe = (state_ff == ST_READ) & rd_act;
  wire [DATA_W-1:0] nxt_dout = rd_stb_ff ? reg_rd_data : dout_ff;
  // Host data is sampled every cycle of the write window; the last sample is committed.
  wire [DATA_W-1:0] nxt_wdata = (start_wr | ((state_ff == ST_WRITE) & wr_act)) ? data_s : wdata_ff;
  wire [ADDR_W-1:0] nxt_addr = (start_rd | start_wr) ? eff_addr : addr_ff;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      rd_stb_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
      oe_ff <= 1'b0;
      irq_n_ff <= IRQ_N_RST;
      addr_ff <= ADDR_RST;
      wdata_ff <= DATA_RST;
      dout_ff <= DATA_RST;
    end else begin
      state_ff <= nxt_state;
      rd_stb_ff <= start_rd;
      wr_stb_ff <= end_wr;
      oe_ff <= nxt_oe;
      irq_n_ff <= ~event_req;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      dout_ff <= nxt_dout;
    end
  end

  assign host_data_out = dout_ff;
  assign host_data_oe = oe_ff;
  assign irq_n = irq_n_ff;
  assign reg_rd_stb = rd_stb_ff;
  assign reg_wr_stb = wr_stb_ff;
  assign reg_addr = addr_ff;
  assign reg_wr_data = wdata_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  style_single_a: assert property (
    (idle && style_s && !cs_s && !wr_s) |=> (state_ff == ST_WRITE) && !rd_stb_ff
  ) else $error("single-strobe write not taken");

  style_split_a: assert property (
    (idle && !style_s && !cs_s && !rd_s) |=> rd_stb_ff ##1 !rd_stb_ff
  ) else $error("split-strobe read not taken as one pulse");

  rd_window_a: assert property (
    host_data_oe |-> $past(rd_act) && $past(state_ff == ST_READ)
  ) else $error("data driven outside the read window");

  wr_commit_a: assert property (
    reg_wr_stb |-> $past(state_ff == ST_WRITE) && !$past(wr_act) && (reg_wr_data == $past(wdata_ff))
  ) else $error("write committed outside window end");

  reset_hold_a: assert property (
    disable iff (1'b0) reset |-> irq_n && !host_data_oe && !reg_rd_stb && !reg_wr_stb
  ) else $error("outputs not held during reset");

  irq_follow_a: assert property (
    event_req |=> !irq_n
  ) else $error("interrupt request not raised");

  rd_data_a: assert property (
    reg_rd_stb |=> (host_data_out == $past(reg_rd_data)) ##1 (host_data_out == $past(reg_rd_data, 2))
  ) else $error("read data not presented");

  oe_release_a: assert property (
    (state_ff == ST_READ && !rd_act) |=> !host_data_oe && (state_ff == ST_IDLE)
  ) else $error("data bus not released");

  mux_latch_a: assert property (
    (ale_s && mux_s) |=> ale_addr_ff == {$past(addr_s[ADDR_W-1:DATA_W]), $past(data_s)}
  ) else $error("multiplexed address not latched");

  no_cs_a: assert property (
    (idle && cs_s) |=> !reg_rd_stb && (state_ff == ST_IDLE) && !host_data_oe
  ) else $error("access without chip select");

  read_cover_c: cover property (start_rd ##1 rd_stb_ff ##[1:10] host_data_oe);
  write_cover_c: cover property (start_wr ##[1:20] reg_wr_stb);
  mux_cover_c: cover property ((ale_s && mux_s) ##[1:20] reg_rd_stb);
  irq_cover_c: cover property (!irq_n ##1 irq_n);

endmodule : host_control_port

// ### verification/host_bus_model.sv
module host_bus_model
  import host_port_pkg::*;
(
  input wire logic core_clk,
  output logic bus_style,
  output logic addr_mux,
  output logic ale,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] host_addr,
  output logic [DATA_W-1:0] host_data_in,
  input wire logic [DATA_W-1:0] host_data_out,
  input wire logic host_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_en = 1'b0;
  logic [DATA_W-1:0] host_d = 8'h00;
  // A released bus shows the inverse of the last host value, never a stale copy.
  assign host_data_in = host_data_oe ? host_data_out : (host_en ? host_d : ~host_d);
  initial begin
    {bus_style, addr_mux, ale} = 3'h0;
    {chip_select_n, read_strobe_n, write_strobe_n} = 3'h7;
    host_addr = 10'h000;
  end

  task automatic set_mode(input logic style, input logic mux);
    @(negedge core_clk);
    bus_style = style;
    addr_mux = mux;
  endtask : set_mode

  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic sel, output logic [DATA_W-1:0] q);
    @(negedge core_clk);
    host_addr = a;
    if (addr_mux) begin
      host_d = a[DATA_W-1:0];
      host_en = 1'b1;
      ale = 1'b1;
      repeat (3) @(negedge core_clk);
      ale = 1'b0;
      @(negedge core_clk);
    end
    host_en = wr;
    host_d = d;
    if (bus_style) write_strobe_n = ~wr;
    @(negedge core_clk);
    chip_select_n = ~sel;
    if (!bus_style) begin
      read_strobe_n = wr;
      write_strobe_n = ~wr;
    end
    repeat (7) @(negedge core_clk);
    q = host_data_in;
    {chip_select_n, read_strobe_n, write_strobe_n} = 3'h7;
    host_en = 1'b0;
    repeat (5) @(negedge core_clk);
  endtask : access
endmodule : host_bus_model

// ### verification/host_control_port_tb.sv
module host_control_port_tb;
  import host_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, event_req;
  logic bus_style, addr_mux, ale, chip_select_n, read_strobe_n, write_strobe_n;
  logic host_data_oe, irq_n, reg_rd_stb, reg_wr_stb;
  logic [ADDR_W-1:0] host_addr, reg_addr, seen_addr;
  logic [DATA_W-1:0] host_data_in, host_data_out, reg_wr_data, reg_rd_data, seen_wdata, q;
  int error_cnt = 0, check_count = 0, cycles = 0, rd_cnt = 0, wr_cnt = 0, oe_cnt = 0;

  // Core side answers with a pattern derived from the address.
  assign reg_rd_data = reg_addr[7:0] ^ 8'h5a;

  host_control_port DUT (.core_clk(core_clk), .reset(reset), .bus_style(bus_style), .addr_mux(addr_mux),
    .ale(ale), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .irq_n(irq_n), .event_req(event_req), .reg_rd_stb(reg_rd_stb),
    .reg_wr_stb(reg_wr_stb), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
  host_bus_model host (.core_clk(core_clk), .bus_style(bus_style), .addr_mux(addr_mux), .ale(ale),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (reg_rd_stb === 1'b1) rd_cnt++;
    if (host_data_oe === 1'b1) oe_cnt++;
    if (reg_wr_stb === 1'b1) begin
      wr_cnt++;
      seen_wdata <= reg_wr_data;
    end
    if (reg_rd_stb === 1'b1 || reg_wr_stb === 1'b1) seen_addr <= reg_addr;
    if (cycles == 4000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int w0 = wr_cnt;
    host.access(1'b1, a, d, 1'b1, q);
    check("write count", 16'(wr_cnt - w0), 16'h0001);
    check("write addr", 16'(seen_addr), 16'(a));
    check("write data", 16'(seen_wdata), 16'(d));
  endtask : wr_chk

  task automatic rd_chk(input logic [ADDR_W-1:0] a);
    int r0 = rd_cnt;
    host.access(1'b0, a, 8'h00, 1'b1, q);
    check("read count", 16'(rd_cnt - r0), 16'h0001);
    check("read addr", 16'(seen_addr), 16'(a));
    check("read data", 16'(q), 16'(a[7:0] ^ 8'h5a));
  endtask : rd_chk

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic split_access();
    host.set_mode(1'b0, 1'b0);
    wr_chk(10'h3a5, 8'hc3);
    rd_chk(10'h0ff);
  endtask : split_access

  task automatic single_access();
    host.set_mode(1'b1, 1'b0);
    wr_chk(10'h201, 8'h3c);
    rd_chk(10'h155);
  endtask : single_access

  task automatic mux_access();
    host.set_mode(1'b0, 1'b1);
    wr_chk(10'h2e7, 8'h81);
    host.set_mode(1'b1, 1'b1);
    rd_chk(10'h1c4);
  endtask : mux_access

  task automatic deselected();
    int w0 = wr_cnt, r0 = rd_cnt, o0 = oe_cnt;
    host.set_mode(1'b0, 1'b0);
    host.access(1'b1, 10'h011, 8'h77, 1'b0, q);
    host.access(1'b0, 10'h022, 8'h66, 1'b0, q);
    check("bus undriven", 16'(q), 16'h0099);
    check("strobes ignored", 16'(wr_cnt - w0 + rd_cnt - r0 + oe_cnt - o0), 16'h0000);
  endtask : deselected

  task automatic irq_and_reset();
    @(negedge core_clk);
    event_req = 1'b1;
    #1;
    check("irq before", 16'(irq_n), 16'h0001);
    @(negedge core_clk);
    check("irq raised", 16'(irq_n), 16'h0000);
    reset = 1'b1;
    #1;
    check("irq in reset", 16'(irq_n), 16'h0001);
    repeat (5) @(negedge core_clk);
    check("held in reset", 16'({irq_n, host_data_oe}), 16'h0002);
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
    check("irq after", 16'(irq_n), 16'h0000);
    event_req = 1'b0;
    @(negedge core_clk);
  endtask : irq_and_reset

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    // Reset rises on a falling edge so the asynchronous reset always sees a real edge.
    reset = 1'b0;
    event_req = 1'b0;
    @(negedge core_clk);
    reset = 1'b1;
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    split_access();
    single_access();
    mux_access();
    deselected();
    irq_and_reset();
    tally_and_finish();
  end
endmodule : host_control_port_tb
